// >>> src/arp_params.svh
// constants of the conversion result readout port
// Behaviour
// - outputs high impedance unless select and read low
// - output code selectable except full-width parallel
// - parallel bus width of 18, 16 or 8
// - both bus config bits high select serial
// - eighteen bits shifted out, msb first
// - serial bit stable across both clock edges
// - master mode drives shift clock and frame
// - master clock and frame polarity invertible
// - read timing picks after or during conversion
// - master read-after keeps busy until shifted
// - divider input slows generated shift clock
// - slave shifts only while select, read low
// - slave clock continuous or gated, either idle
// - slave read after busy falls, 40 MHz
// - daisy chain only when reading after conversion
// - chain input taken on the opposite edge
// - incomplete read during conversion flags overrun
// - read may run into the next conversion
// - started conversion cannot be aborted or restarted
// - start held low restarts conversions automatically
`ifndef ARP_PARAMS_SVH
`define ARP_PARAMS_SVH

`define ARP_RES_W          18
`define ARP_MSB            17
`define ARP_HI16_LSB       2
`define ARP_HI8_LSB        10
`define ARP_LAST_BIT       5'h11
`define ARP_BIT_FULL       5'h12
`define ARP_PTR_LAST16     2'h1
`define ARP_PTR_LAST8      2'h2
`define ARP_CLK_PERIOD_NS  5
`define ARP_CONV_TIME_NS   8000
`define ARP_CONV_CYC       ((`ARP_CONV_TIME_NS + `ARP_CLK_PERIOD_NS - 1) / `ARP_CLK_PERIOD_NS)
`define ARP_SCLK_PHASE_NS  10
`define ARP_SCLK_PHASE_CYC (`ARP_SCLK_PHASE_NS / `ARP_CLK_PERIOD_NS)
`define ARP_SCLK_DIV       4
`define ARP_FIFO_DEPTH     8

`endif

// >>> src/arp_pkg.sv
// types shared by the readout port modules
package arp_pkg;
	typedef enum logic [1:0] {
		ARP_BUS18  = 2'h0,
		ARP_BUS16  = 2'h1,
		ARP_BUS8   = 2'h2,
		ARP_SERIAL = 2'h3
	} arp_bus_t;

	typedef enum logic [1:0] {
		ARP_M_IDLE = 2'h0,
		ARP_M_SET  = 2'h1,
		ARP_M_HI   = 2'h3,
		ARP_M_LO   = 2'h2
	} arp_mst_t;
endpackage

// >>> src/arp_fifo.sv
// sample fifo between the converter core and the result register
`timescale 1ns/1ps
`default_nettype none
module arp_fifo #(
	parameter int W     = 18,
	parameter int DEPTH = 8
) (
	// clock and reset
	input  wire logic         clk,
	input  wire logic         resetn,
	// fill side
	input  wire logic         in_valid,
	output logic              in_ready,
	input  wire logic [W-1:0] in_data,
	// drain side
	output logic              out_valid,
	input  wire logic         out_ready,
	output logic [W-1:0]      out_data
);
	localparam int AW = $clog2(DEPTH);
	localparam int CW = AW + 1;

	if (DEPTH < 2 || (1 << AW) != DEPTH || W < 1) begin : g_chk
		$error("fifo depth must be a power of two, at least 2");
	end

	logic [W-1:0]  mem [DEPTH];
	logic [AW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
	logic [CW-1:0] cnt_r, cnt_nxt;
	logic          rdy_r, rdy_nxt, vld_r, vld_nxt;
	logic          push, pop;

	assign push      = in_valid && rdy_r;
	assign pop       = out_ready && vld_r;
	assign in_ready  = rdy_r;
	assign out_valid = vld_r;
	assign out_data  = mem[rp_r];

	always_comb begin
		wp_nxt  = push ? wp_r + AW'(1) : wp_r;
		rp_nxt  = pop ? rp_r + AW'(1) : rp_r;
		cnt_nxt = cnt_r + CW'(push) - CW'(pop);
		// flags registered so both handshakes come from flops
		rdy_nxt = cnt_nxt != CW'(DEPTH);
		vld_nxt = cnt_nxt != CW'(0);
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			wp_r  <= '0;
			rp_r  <= '0;
			cnt_r <= '0;
			rdy_r <= 1'b0;
			vld_r <= 1'b0;
		end else begin
			wp_r  <= wp_nxt;
			rp_r  <= rp_nxt;
			cnt_r <= cnt_nxt;
			rdy_r <= rdy_nxt;
			vld_r <= vld_nxt;
		end
	end

	always_ff @(posedge clk) begin
		if (push)
			mem[wp_r] <= in_data;
	end
endmodule
`default_nettype wire

// >>> src/arp_conv.sv
// conversion timer: start, busy and completion of one conversion
`timescale 1ns/1ps
`default_nettype none
`include "arp_params.svh"
module arp_conv #(
	parameter int CONV_CYC = `ARP_CONV_CYC
) (
	// clock and reset
	input  wire logic clk,
	input  wire logic resetn,
	// control
	input  wire logic convert_start_n,
	input  wire logic power_down_input,
	input  wire logic hold,
	// status
	output logic      busy,
	output logic      start,
	output logic      done
);
	localparam int CW = $clog2(CONV_CYC + 1);

	if (CONV_CYC < 4) begin : g_chk
		$error("conversion must last at least four cycles");
	end

	logic [CW-1:0] cnt_r, cnt_nxt;
	logic          busy_r, busy_nxt;

	// power-down only blocks new starts, never a running one
	assign start = !busy_r && !hold && !convert_start_n
		&& !power_down_input;
	assign done  = busy_r && cnt_r == CW'(1);
	assign busy  = busy_r;

	always_comb begin
		cnt_nxt  = cnt_r;
		busy_nxt = busy_r;
		if (start) begin
			cnt_nxt  = CW'(CONV_CYC);
			busy_nxt = 1'b1;
		end else if (busy_r) begin
			cnt_nxt = cnt_r - CW'(1);
			if (done)
				busy_nxt = 1'b0;
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			cnt_r  <= '0;
			busy_r <= 1'b0;
		end else begin
			cnt_r  <= cnt_nxt;
			busy_r <= busy_nxt;
		end
	end

	a_no_abort:
	assert property (@(posedge clk) disable iff (!resetn)
		(busy_r && !done) |=> busy_r && !start)
	else $error("conversion ended early");

	a_auto_start:
	assert property (@(posedge clk) disable iff (!resetn)
		(!busy_r && !hold && !convert_start_n && !power_down_input)
		|=> busy_r && cnt_r == CW'(CONV_CYC))
	else $error("held start did not begin a conversion");
endmodule
`default_nettype wire

// >>> src/arp_readout.sv
// result readout port: parallel bus, master and slave serial
`timescale 1ns/1ps
`default_nettype none
`include "arp_params.svh"
module arp_readout
	import arp_pkg::*;
#(
	parameter int CONV_CYC   = `ARP_CONV_CYC,
	parameter int SCLK_PHASE = `ARP_SCLK_PHASE_CYC,
	parameter int SCLK_DIV   = `ARP_SCLK_DIV
) (
	// clock and reset
	input  wire logic                  clk,
	input  wire logic                  resetn,
	// sample source
	input  wire logic [`ARP_MSB:0]     smp_data,
	input  wire logic                  smp_valid,
	output logic                       smp_ready,
	// conversion control
	input  wire logic                  convert_start_n,
	input  wire logic                  power_down_input,
	output logic                       busy,
	// configuration
	input  wire logic                  bus_cfg_bit0,
	input  wire logic                  bus_cfg_bit1,
	input  wire logic                  output_code_select,
	input  wire logic                  clock_source_select,
	input  wire logic                  read_timing_or_chain_input,
	input  wire logic                  shift_clock_divider,
	input  wire logic                  sclk_invert,
	input  wire logic                  sync_invert,
	// data bus
	input  wire logic                  cs_n,
	input  wire logic                  rd_n,
	output logic [`ARP_MSB:0]          data_out,
	output logic                       data_oe,
	output logic                       serial_result_out,
	// serial clock and frame
	input  wire logic                  sclk_in,
	output logic                       sclk_out,
	output logic                       sclk_oe,
	output logic                       sync_out,
	output logic                       read_overrun_flag
);
	localparam int PW = $clog2(SCLK_PHASE * SCLK_DIV + 1);

	if (SCLK_PHASE < 1 || SCLK_DIV < 2 || CONV_CYC < 4) begin : g_chk
		$error("unsupported shift clock or conversion timing");
	end

	function automatic logic [`ARP_MSB:0] arp_code(
		input logic [`ARP_MSB:0] raw,
		input logic              ob,
		input arp_bus_t          m);
		arp_code = raw;
		if (m != ARP_BUS18 && ob)
			arp_code[`ARP_MSB] = ~raw[`ARP_MSB];
	endfunction

	function automatic logic [`ARP_MSB:0] arp_word(
		input logic [`ARP_MSB:0] w,
		input arp_bus_t          m,
		input logic [1:0]        p);
		arp_word = w;
		if (m == ARP_BUS16)
			arp_word = (p == 2'h0) ? `ARP_RES_W'(w >> `ARP_HI16_LSB)
				: `ARP_RES_W'(w[`ARP_HI16_LSB-1:0]);
		else if (m == ARP_BUS8)
			case (p)
			2'h0: arp_word = `ARP_RES_W'(w >> `ARP_HI8_LSB);
			2'h1: arp_word = `ARP_RES_W'(w[`ARP_HI8_LSB-1:`ARP_HI16_LSB]);
			default: arp_word = `ARP_RES_W'(w[`ARP_HI16_LSB-1:0]);
			endcase
	endfunction

	arp_bus_t          bmode;
	logic              ser, mst, slv, par, rdc, sel;
	logic              conv_busy, conv_start, conv_end;
	logic              f_vld;
	logic [`ARP_MSB:0] f_data, cw;

	assign bmode = arp_bus_t'({bus_cfg_bit1, bus_cfg_bit0});
	assign ser = bmode == ARP_SERIAL;
	assign par = !ser;
	assign mst = ser && !clock_source_select;
	assign slv = ser && clock_source_select;
	assign rdc = read_timing_or_chain_input;
	assign sel = !cs_n && !rd_n;

	arp_fifo #(.W(`ARP_RES_W), .DEPTH(`ARP_FIFO_DEPTH)) u_fifo (
		.clk       (clk),
		.resetn    (resetn),
		.in_valid  (smp_valid),
		.in_ready  (smp_ready),
		.in_data   (smp_data),
		.out_valid (f_vld),
		.out_ready (conv_end),
		.out_data  (f_data)
	);

	logic hold_r, hold_nxt;

	arp_conv #(.CONV_CYC(CONV_CYC)) u_conv (
		.clk              (clk),
		.resetn           (resetn),
		.convert_start_n  (convert_start_n),
		.power_down_input (power_down_input),
		.hold             (hold_r),
		.busy             (conv_busy),
		.start            (conv_start),
		.done             (conv_end)
	);

	// result register: an empty fifo leaves the old result in place
	logic [`ARP_MSB:0] res_r, res_nxt;
	logic              ld_r;

	always_comb begin
		res_nxt = res_r;
		if (conv_end && f_vld)
			res_nxt = f_data;
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			res_r <= '0;
			ld_r  <= 1'b0;
		end else begin
			res_r <= res_nxt;
			ld_r  <= conv_end;
		end
	end

	assign cw = arp_code(res_r, output_code_select, bmode);

	// master shifter: set, high, low phases keep data stable round
	// both clock edges at the cost of a three-phase bit period
	arp_mst_t      m_st_r, m_st_nxt;
	logic [PW-1:0] ph_r, ph_nxt, per;
	logic [4:0]    bit_r, bit_nxt;
	logic          m_div_r, m_div_nxt, ph_end, m_go, m_shift;

	assign per = m_div_r ? PW'(SCLK_PHASE * SCLK_DIV)
		: PW'(SCLK_PHASE);
	assign ph_end = ph_r == per - PW'(1);
	assign m_go = mst && (rdc ? conv_start : ld_r);

	always_comb begin
		m_st_nxt  = m_st_r;
		ph_nxt    = ph_r;
		bit_nxt   = bit_r;
		m_div_nxt = m_div_r;
		hold_nxt  = hold_r;
		m_shift   = 1'b0;
		if (conv_end && mst && !rdc)
			hold_nxt = 1'b1;
		if (!mst)
			hold_nxt = 1'b0;
		if (m_st_r != ARP_M_IDLE)
			ph_nxt = ph_end ? PW'(0) : ph_r + PW'(1);
		case (m_st_r)
		ARP_M_IDLE: begin
			if (m_go) begin
				m_st_nxt  = ARP_M_SET;
				ph_nxt    = PW'(0);
				bit_nxt   = 5'h0;
				m_div_nxt = shift_clock_divider;
			end
		end
		ARP_M_SET: if (ph_end) m_st_nxt = ARP_M_HI;
		ARP_M_HI: if (ph_end) m_st_nxt = ARP_M_LO;
		ARP_M_LO: begin
			if (ph_end) begin
				if (bit_r == `ARP_LAST_BIT) begin
					m_st_nxt = ARP_M_IDLE;
					hold_nxt = 1'b0;
				end else begin
					m_st_nxt = ARP_M_SET;
					bit_nxt  = bit_r + 5'h1;
					m_shift  = 1'b1;
				end
			end
		end
		default: m_st_nxt = ARP_M_IDLE;
		endcase
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			m_st_r  <= ARP_M_IDLE;
			ph_r    <= '0;
			bit_r   <= 5'h0;
			m_div_r <= 1'b0;
			hold_r  <= 1'b0;
		end else begin
			m_st_r  <= m_st_nxt;
			ph_r    <= ph_nxt;
			bit_r   <= bit_nxt;
			m_div_r <= m_div_nxt;
			hold_r  <= hold_nxt;
		end
	end

	// slave side: edges of the host clock, gated by select and read
	logic       sclk_prev_r, armed_r, arm_nxt, chain_r, chain_nxt;
	// no edge until one real sample: an idle-high clock at reset
	// release would otherwise look like a rise and arm a false read
	logic       sclk_seen_r;
	logic       rise, fall, s_shift, ovr_nxt;
	logic [4:0] cnt_r, cnt_nxt;

	assign rise = slv && sel && sclk_seen_r
		&& sclk_in && !sclk_prev_r;
	assign fall = slv && sel && sclk_seen_r
		&& !sclk_in && sclk_prev_r;

	always_comb begin
		arm_nxt   = armed_r;
		chain_nxt = chain_r;
		cnt_nxt   = cnt_r;
		s_shift   = 1'b0;
		if (rise) begin
			arm_nxt   = 1'b1;
			// chain input sampled on the non-shifting edge
			chain_nxt = !conv_busy && rdc;
			if (cnt_r != `ARP_BIT_FULL)
				cnt_nxt = cnt_r + 5'h1;
		end
		// a falling edge with no rise before it is an idle-high start
		if (fall && armed_r) begin
			arm_nxt = 1'b0;
			s_shift = 1'b1;
		end
		// reload only at completion lets a late read run on
		if (ld_r && slv) begin
			cnt_nxt = 5'h0;
			arm_nxt = 1'b0;
		end
		ovr_nxt = slv && conv_end && cnt_r != 5'h0
			&& cnt_r < `ARP_BIT_FULL;
	end

	// shared output shift register
	logic [`ARP_MSB:0] sh_r, sh_nxt;

	always_comb begin
		sh_nxt = sh_r;
		if ((slv && ld_r) || m_go)
			sh_nxt = cw;
		else if (m_shift)
			sh_nxt = {sh_r[`ARP_MSB-1:0], 1'b0};
		else if (s_shift)
			sh_nxt = {sh_r[`ARP_MSB-1:0], chain_r};
	end

	// parallel word pointer steps on each end of read
	logic       rd_prev_r, rd_rise;
	logic [1:0] ptr_r, ptr_nxt, ptr_last;

	assign rd_rise = par && !cs_n && rd_n && !rd_prev_r;
	assign ptr_last = (bmode == ARP_BUS8) ? `ARP_PTR_LAST8
		: (bmode == ARP_BUS16) ? `ARP_PTR_LAST16 : 2'h0;

	always_comb begin
		ptr_nxt = ptr_r;
		if (ld_r)
			ptr_nxt = 2'h0;
		else if (rd_rise)
			ptr_nxt = (ptr_r >= ptr_last) ? 2'h0 : ptr_r + 2'h1;
	end

	logic [`ARP_MSB:0] dout_r, dout_nxt;
	logic oe_r, oe_nxt, sdo_r, sdo_nxt, sck_r, sck_nxt, sck_oe_r;
	logic sck_oe_nxt, sync_r, sync_nxt, busy_r, busy_nxt, ovr_r;

	always_comb begin
		oe_nxt     = sel;
		dout_nxt   = par ? arp_word(cw, bmode, ptr_nxt) : '0;
		sdo_nxt    = sh_nxt[`ARP_MSB];
		sck_nxt    = (m_st_nxt == ARP_M_HI) ^ sclk_invert;
		sck_oe_nxt = mst && sel;
		sync_nxt   = (m_st_nxt != ARP_M_IDLE) ^ sync_invert;
		busy_nxt   = conv_busy || hold_nxt;
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			sclk_prev_r <= 1'b0;
			sclk_seen_r <= 1'b0;
			armed_r     <= 1'b0;
			chain_r     <= 1'b0;
			cnt_r       <= 5'h0;
			sh_r        <= '0;
			rd_prev_r   <= 1'b1;
			ptr_r       <= 2'h0;
			dout_r      <= '0;
			oe_r        <= 1'b0;
			sdo_r       <= 1'b0;
			sck_r       <= 1'b0;
			sck_oe_r    <= 1'b0;
			sync_r      <= 1'b0;
			busy_r      <= 1'b0;
			ovr_r       <= 1'b0;
		end else begin
			sclk_prev_r <= sclk_in;
			sclk_seen_r <= 1'b1;
			armed_r     <= arm_nxt;
			chain_r     <= chain_nxt;
			cnt_r       <= cnt_nxt;
			sh_r        <= sh_nxt;
			rd_prev_r   <= rd_n;
			ptr_r       <= ptr_nxt;
			dout_r      <= dout_nxt;
			oe_r        <= oe_nxt;
			sdo_r       <= sdo_nxt;
			sck_r       <= sck_nxt;
			sck_oe_r    <= sck_oe_nxt;
			sync_r      <= sync_nxt;
			busy_r      <= busy_nxt;
			ovr_r       <= ovr_nxt;
		end
	end

	assign data_out          = dout_r;
	assign data_oe           = oe_r;
	assign serial_result_out = sdo_r;
	assign sclk_out          = sck_r;
	assign sclk_oe           = sck_oe_r;
	assign sync_out          = sync_r;
	assign busy              = busy_r;
	assign read_overrun_flag = ovr_r;

	a_hiz_desel:
	assert property (@(posedge clk) disable iff (!resetn)
		(cs_n || rd_n) |=> !data_oe && !sclk_oe)
	else $error("outputs driven while deselected");

	a_code_flip:
	assert property (@(posedge clk) disable iff (!resetn)
		(bmode != ARP_BUS18) |-> (cw[`ARP_MSB] != res_r[`ARP_MSB])
			== output_code_select)
	else $error("output code select not applied");

	a_byte_wrap:
	assert property (@(posedge clk) disable iff (!resetn)
		(rd_rise && !ld_r && bmode == ARP_BUS8
			&& ptr_r == `ARP_PTR_LAST8) |=> ptr_r == 2'h0)
	else $error("byte pointer did not wrap after third byte");

	a_last_bit:
	assert property (@(posedge clk) disable iff (!resetn)
		(m_st_r == ARP_M_LO && ph_end && bit_r == `ARP_LAST_BIT)
		|=> m_st_r == ARP_M_IDLE && !hold_r)
	else $error("master frame not closed after last bit");

	a_div_phase:
	assert property (@(posedge clk) disable iff (!resetn)
		($rose(m_st_r == ARP_M_HI) && m_div_r)
		|-> (m_st_r == ARP_M_HI)[*8] ##1 (m_st_r == ARP_M_LO))
	else $error("divided clock high phase has wrong length");

	a_busy_hold:
	assert property (@(posedge clk) disable iff (!resetn)
		hold_r |-> busy && !u_conv.start)
	else $error("busy fell before master shift completed");

	a_chain_off:
	assert property (@(posedge clk) disable iff (!resetn)
		(rise && conv_busy) |=> !chain_r)
	else $error("chain input taken during conversion");

	a_chain_shift:
	assert property (@(posedge clk) disable iff (!resetn)
		(fall && armed_r && !ld_r && !m_go)
		|=> sh_r[0] == $past(chain_r))
	else $error("chain bit not shifted in on falling edge");

	a_overrun:
	assert property (@(posedge clk) disable iff (!resetn)
		(slv && conv_end && cnt_r != 5'h0 && cnt_r < `ARP_BIT_FULL)
		|=> read_overrun_flag ##1 !read_overrun_flag)
	else $error("incomplete read not flagged as overrun");
endmodule
`default_nettype wire

// >>> dv/arp_host_model.sv
// host side serial reader driving the shift clock and chain input
`timescale 1ns/1ps
`default_nettype none
module arp_host_model (
	// clock
	input  wire logic       clk,
	// command
	input  wire logic       go,
	input  wire logic [4:0] n,
	input  wire logic [5:0] pat,
	// serial link
	input  wire logic       sdo,
	output logic            sclk_in,
	output logic            chain,
	// result
	output logic [23:0]     got,
	output logic            busy_o
);
	int j;

	initial begin
		sclk_in = 1'b0;
		chain = 1'b0;
		got = '0;
		busy_o = 1'b0;
	end

	// clock idles low and only runs while a read is commanded
	always begin
		@(posedge clk);
		if (go === 1'b1) begin
			#1;
			busy_o = 1'b1;
			chain = pat[5];
			for (j = 0; j < n; j++) begin
				repeat (3) @(posedge clk);
				#1;
				got = {got[22:0], sdo};
				sclk_in = 1'b1;
				repeat (3) @(posedge clk);
				#1;
				sclk_in = 1'b0;
				chain = (j < 5) ? pat[4 - j] : 1'b0;
			end
			repeat (3) @(posedge clk);
			#1;
			busy_o = 1'b0;
		end
	end
endmodule
`default_nettype wire

// >>> dv/tb_arp_readout.sv
// self-checking bench of the conversion result readout port
`timescale 1ns/1ps
`default_nettype none
module tb_arp_readout;
	localparam int CONV = 400;
	logic        clk, resetn, smp_valid, smp_ready, convert_start_n;
	logic        power_down_input, busy, bus_cfg_bit0, bus_cfg_bit1;
	logic        output_code_select, clock_source_select, rdc_tb;
	logic        read_timing_or_chain_input, shift_clock_divider;
	logic        sclk_invert, sync_invert, cs_n, rd_n, data_oe;
	logic        serial_result_out, sclk_in, sclk_out, sclk_oe;
	logic        sync_out, read_overrun_flag, h_go, h_busy, h_chain, sp;
	logic [17:0] smp_data, data_out, mbits;
	logic [23:0] h_got;
	logic [5:0]  h_pat;
	logic [4:0]  h_n;
	int          err_total, compares, sync_n, ovr_n, cyc;

	arp_readout #(.CONV_CYC(CONV)) dut (
		.clk, .resetn, .smp_data, .smp_valid, .smp_ready,
		.convert_start_n, .power_down_input, .busy, .bus_cfg_bit0,
		.bus_cfg_bit1, .output_code_select, .clock_source_select,
		.read_timing_or_chain_input, .shift_clock_divider, .sclk_invert,
		.sync_invert, .cs_n, .rd_n, .data_out, .data_oe, .serial_result_out,
		.sclk_in, .sclk_out, .sclk_oe, .sync_out, .read_overrun_flag
	);
	arp_host_model host (
		.clk, .go(h_go), .n(h_n), .pat(h_pat), .sdo(serial_result_out),
		.sclk_in, .chain(h_chain), .got(h_got), .busy_o(h_busy)
	);
	assign read_timing_or_chain_input =
		clock_source_select ? h_chain : rdc_tb;

	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	// master frame monitor, overrun counter and hang limit
	always @(posedge clk) begin
		sp <= sclk_out ^ sclk_invert;
		if ((sync_out ^ sync_invert) === 1'b1)
			sync_n <= sync_n + 1;
		if ((sclk_out ^ sclk_invert) === 1'b1 && sp === 1'b0)
			mbits <= {mbits[16:0], serial_result_out};
		if (read_overrun_flag === 1'b1)
			ovr_n <= ovr_n + 1;
		cyc <= cyc + 1;
		if (cyc == 40000) begin
			err_total++;
			complete_run();
		end
	end

	task automatic complete_run;
		$display("compares %0d mismatches %0d", compares, err_total);
		if (err_total == 0 && compares > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	task automatic cmp(input logic [23:0] g, e, input string m);
		compares++;
		if (g !== e) begin
			err_total++;
			$display("MISMATCH t=%0t %s", $time, m);
		end
	endtask

	task automatic fin(input string s);
		$display("test %s done", s);
	endtask

	function automatic logic [17:0] cod(input logic [17:0] v);
		return output_code_select ? {~v[17], v[16:0]} : v;
	endfunction

	task automatic push(input logic [17:0] v);
		smp_data = v;
		smp_valid = 1'b1;
		tick(1);
		smp_valid = 1'b0;
	endtask

	task automatic start;
		convert_start_n = 1'b0;
		tick(1);
		convert_start_n = 1'b1;
	endtask

	task automatic wait_idle(output int w);
		int n;
		n = 0;
		w = 0;
		while (busy !== 1'b1 && n < 5) begin
			tick(1);
			n++;
		end
		while (busy === 1'b1 && w < 1000) begin
			tick(1);
			w++;
		end
		cmp(busy, 0, "busy stuck");
	endtask

	task automatic conv(input logic [17:0] v, output int w);
		push(v);
		start();
		wait_idle(w);
	endtask

	// one bus word; select stays low so the word pointer advances
	task automatic rd(input logic [17:0] e, input string m);
		cs_n = 1'b0;
		rd_n = 1'b0;
		tick(2);
		cmp(data_oe, 1, m);
		cmp(data_out, e, m);
		rd_n = 1'b1;
		tick(2);
	endtask

	task automatic hread(input logic [4:0] n, input logic [5:0] p);
		int k;
		h_n = n;
		h_pat = p;
		h_go = 1'b1;
		tick(1);
		h_go = 1'b0;
		tick(2);
		for (k = 0; k < 400 && h_busy === 1'b1; k++)
			tick(1);
	endtask

	task automatic t_par;
		int w1, w2;
		output_code_select = 1'b1;
		conv(18'h2c3a5, w1);
		cs_n = 1'b0;
		tick(2);
		cmp(data_oe, 0, "oe with read high");
		cs_n = 1'b1;
		rd_n = 1'b0;
		tick(2);
		cmp(data_oe, 0, "oe with select high");
		rd_n = 1'b1;
		tick(1);
		rd(18'h2c3a5, "full width raw");
		cs_n = 1'b1;
		push(18'h1);
		start();
		tick(20);
		start();
		wait_idle(w2);
		cmp(w2 + 20, w1, "restart changed length");
		fin("parallel");
	endtask

	task automatic t_fifo;
		int w, i;
		smp_valid = 1'b1;
		for (i = 0; i < 8; i++) begin
			smp_data = 18'h100 + i[17:0];
			tick(1);
		end
		cmp(smp_ready, 0, "fifo not full");
		// a ninth word offered while full must be refused
		smp_data = 18'h3ffff;
		tick(1);
		smp_valid = 1'b0;
		convert_start_n = 1'b0;
		for (i = 0; i < 8; i++) begin
			wait_idle(w);
			rd(18'h100 + i[17:0], "fifo order");
			cs_n = 1'b1;
		end
		convert_start_n = 1'b1;
		wait_idle(w);
		cmp(smp_ready, 1, "fifo not drained");
		rd(18'h107, "empty fifo kept");
		cs_n = 1'b1;
		fin("fifo");
	endtask

	task automatic t_narrow;
		int w;
		logic [17:0] c;
		bus_cfg_bit0 = 1'b1;
		conv(18'h2b4e7, w);
		c = cod(18'h2b4e7);
		rd({2'h0, c[17:2]}, "w16 high");
		rd({16'h0, c[1:0]}, "w16 low");
		cs_n = 1'b1;
		output_code_select = 1'b0;
		bus_cfg_bit0 = 1'b0;
		bus_cfg_bit1 = 1'b1;
		conv(18'h2b4e7, w);
		rd({10'h0, 8'had}, "w8 first");
		rd({10'h0, 8'h39}, "w8 second");
		rd({16'h0, 2'h3}, "w8 third");
		cs_n = 1'b1;
		fin("narrow");
	endtask

	task automatic t_slave;
		int w;
		output_code_select = 1'b1;
		bus_cfg_bit0 = 1'b1;
		clock_source_select = 1'b1;
		conv(18'h15a3c, w);
		rd_n = 1'b0;
		hread(5'd3, 6'h0);
		cs_n = 1'b0;
		hread(5'd24, 6'h2d);
		cmp(h_got, {cod(18'h15a3c), 6'h2d}, "chain read");
		cmp(data_out, 0, "parallel in serial");
		fin("slave");
	endtask

	task automatic t_during;
		int w, o;
		conv(18'h0b71d, w);
		push(18'h3e2c1);
		start();
		hread(5'd18, 6'h0);
		cmp(h_got[17:0], cod(18'h0b71d), "previous");
		o = ovr_n;
		wait_idle(w);
		tick(3);
		cmp(ovr_n - o, 0, "false overrun");
		push(18'h1c0de);
		start();
		hread(5'd5, 6'h0);
		o = ovr_n;
		wait_idle(w);
		tick(3);
		cmp(ovr_n - o, 1, "no overrun");
		hread(5'd10, 6'h0);
		push(18'h00f0f);
		start();
		hread(5'd8, 6'h0);
		cmp(h_got[17:0], cod(18'h1c0de), "spanning read");
		o = ovr_n;
		wait_idle(w);
		tick(3);
		cmp(ovr_n - o, 0, "span overrun");
		fin("during");
	endtask

	task automatic mst(input logic [17:0] v, e, input logic dv, rt, inv);
		int w, f, fl;
		clock_source_select = 1'b0;
		shift_clock_divider = dv;
		sclk_invert = inv;
		sync_invert = inv;
		rdc_tb = rt;
		tick(2);
		cmp(sync_out, inv, "frame idle level");
		sync_n = 0;
		fl = dv ? 432 : 108;
		f = rt ? 0 : fl;
		conv(v, w);
		tick(4);
		cmp(sclk_oe, 1, "clock not driven");
		cmp(mbits, e, "master bits");
		cmp(sync_n >= fl - 1 && sync_n <= fl + 1, 1, "frame");
		cmp(w >= CONV + f - 2 && w <= CONV + f + 8, 1, "busy");
		fin("master");
	endtask

	initial begin
		{resetn, smp_valid, power_down_input, bus_cfg_bit0} = '0;
		{bus_cfg_bit1, output_code_select, clock_source_select} = '0;
		{rdc_tb, shift_clock_divider, sclk_invert, sync_invert} = '0;
		{h_go, h_n, h_pat, smp_data} = '0;
		{convert_start_n, cs_n, rd_n} = 3'h7;
		{err_total, compares, sync_n, ovr_n, cyc} = '0;
		repeat (5) @(posedge clk);
		#1;
		resetn = 1'b1;
		tick(2);
		cmp(busy, 0, "busy after reset");
		cmp(data_oe, 0, "oe after reset");
		cmp(smp_ready, 1, "ready after reset");
		t_par();
		t_fifo();
		t_narrow();
		t_slave();
		t_during();
		cs_n = 1'b0;
		rd_n = 1'b0;
		mst(18'h2a5c3, cod(18'h2a5c3), 1'b0, 1'b0, 1'b0);
		mst(18'h0d3e6, cod(18'h0d3e6), 1'b1, 1'b0, 1'b1);
		mst(18'h31f08, cod(18'h0d3e6), 1'b0, 1'b1, 1'b0);
		complete_run();
	end
endmodule
`default_nettype wire
